// ==== verilog/dbg_id_pkg.sv ====
// Package for the debug component identification register window.
// Assumes a single APB slave port, 12-bit block offset, 32-bit data.
package dbg_id_pkg;
    // ==========================================================
    // Address and geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WIDX_HI = 11;
    localparam int unsigned WIDX_LO = 2;
    localparam int unsigned WIDX_W = 10;
    typedef logic [WIDX_W-1:0] widx_t;

    // ==========================================================
    // Register offsets (byte addresses within the 4KB block)
    localparam logic [11:0] OFF_CTRL_FIRST = 12'h000;
    localparam logic [11:0] OFF_INTEG_LAST = 12'hefc;
    localparam logic [11:0] OFF_MGMT_FIRST = 12'hf00;
    localparam logic [11:0] OFF_INTEGRATION_MODE_CONTROL = 12'hf00;
    localparam logic [11:0] OFF_CLAIM_TAG_SET = 12'hf08;
    localparam logic [11:0] OFF_CLAIM_TAG_CLEAR = 12'hf44;
    localparam logic [11:0] OFF_DEVICE_AFFINITY_0 = 12'hfa8;
    localparam logic [11:0] OFF_LOCK_ACCESS = 12'hfb0;
    localparam logic [11:0] OFF_LOCK_STATUS = 12'hfb4;
    localparam logic [11:0] OFF_DEVICE_ARCHITECTURE = 12'hfb8;
    localparam logic [11:0] OFF_DEVICE_CONFIG_2 = 12'hfc0;
    localparam logic [11:0] OFF_DEVICE_CONFIG_1 = 12'hfc4;
    localparam logic [11:0] OFF_DEVICE_CONFIG_0 = 12'hfc8;
    localparam logic [11:0] OFF_DEVICE_TYPE_ID = 12'hfcc;
    localparam logic [11:0] OFF_PERIPH_IDENT_4 = 12'hfd0;
    localparam logic [11:0] OFF_PERIPH_IDENT_0 = 12'hfe0;
    localparam logic [11:0] OFF_COMPONENT_IDENT_0 = 12'hff0;
    localparam logic [11:0] OFF_COMPONENT_IDENT_1 = 12'hff4;
    localparam logic [11:0] OFF_COMPONENT_IDENT_2 = 12'hff8;
    localparam logic [11:0] OFF_COMPONENT_IDENT_3 = 12'hffc;

    // ==========================================================
    // Field values
    localparam logic [7:0] PREAMBLE_BYTE_0 = 8'h00;
    localparam logic [3:0] PREAMBLE_NIBBLE_1 = 4'h0;
    localparam logic [7:0] PREAMBLE_BYTE_2 = 8'h05;
    localparam logic [7:0] PREAMBLE_BYTE_3 = 8'hb1;
    localparam logic [3:0] CLASS_GENERIC_VERIF = 4'h0;
    localparam logic [3:0] CLASS_ADDR_MAP_TABLE = 4'h1;
    localparam logic [3:0] CLASS_DEBUG = 4'h9;
    localparam logic [3:0] CLASS_PERIPH_TEST = 4'hb;
    localparam logic [3:0] CLASS_GENERIC_IP = 4'he;
    localparam logic [3:0] CLASS_LEGACY = 4'hf;
    localparam int unsigned CLAIM_W = 4;
    localparam logic [31:0] UNLOCK_KEY = 32'hc5acce55;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    // Arbitrary neutral identity values
    localparam logic [11:0] PART_NUMBER = 12'h123;
    localparam logic [6:0] DESIGNER_ID = 7'h00;
    localparam logic [3:0] DESIGNER_CONT = 4'h0;
    localparam logic [3:0] REVISION = 4'h0;
    localparam logic [3:0] SIZE_4KB_COUNT = 4'h0;
    localparam logic [7:0] DEVICE_TYPE = 8'h00;

    // ==========================================================
    // APB request carrier
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_s;

    function automatic widx_t word_idx(input logic [11:0] off);
        word_idx = off[WIDX_HI:WIDX_LO];
    endfunction
endpackage

// ==== verilog/debug_component_id_regs.sv ====
// Management and identification register window of a debug component.
// Assumes an APB master on clk; full aligned word accesses only.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - One 4KB block; management registers sit in the highest block.
// - Each register is one 32-bit little-endian word.
// - Only valid low bits stored; full-word access still accepted.
// - Words 0xF00 to 0xFFC hold only management registers.
// - Component control from 0x000 upward, integration from 0xEFC down.
// - Unimplemented optional standard registers read zero.
// - Write-only reads and read-only writes act as reserved: read zero.
// - Reserved fields read fixed zero or one.
// - Unimplemented bits of implemented fields read zero, ignore writes.
// - Reserved values written map onto a permitted behaviour.
// - Component and peripheral identification sets both present.
// - Identification preamble bytes 0x00, 0x0 nibble, 0x05, 0xB1.
// - Second identification word bits 7:4 report component class.
// - Class 0xF denotes legacy component without standard layout.
// - Remaining layout depends on class; this block is class 0x9.
// - Register model reached as a memory-mapped APB slave.
// - Component identification words at 0xFF0 through 0xFFC.
// - Unimplemented management words read zero, writes ignored.
module debug_component_id_regs
    import dbg_id_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Component side
    output logic integration_mode,
    output logic [CLAIM_W-1:0] claim_tags,
    output logic locked
);
    // ==========================================================
    // Request decode
    apb_req_s req;
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    widx_t widx;
    assign widx = req.addr[WIDX_HI:WIDX_LO];

    wire logic setup_phase = req.sel && !req.enable;
    wire logic wr_go = setup_phase && req.write && clk_en;
    wire logic rd_go = setup_phase && !req.write && clk_en;

    wire logic hit_integration_mode_control = widx == word_idx(OFF_INTEGRATION_MODE_CONTROL);
    wire logic hit_cset = widx == word_idx(OFF_CLAIM_TAG_SET);
    wire logic hit_cclr = widx == word_idx(OFF_CLAIM_TAG_CLEAR);
    wire logic hit_lar = widx == word_idx(OFF_LOCK_ACCESS);
    wire logic hit_lsr = widx == word_idx(OFF_LOCK_STATUS);

    // ==========================================================
    // Stored state
    logic integration_mode_control_ff, nxt_integration_mode_control;
    logic [CLAIM_W-1:0] claim_ff;
    wire logic [CLAIM_W-1:0] nxt_claim;
    logic locked_ff, nxt_locked;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic ready_ff, nxt_ready;
    // No error response: refused accesses complete quietly
    logic slverr_ff;

    // Writes are ignored while locked, except the lock access word itself
    wire logic wr_ok = wr_go && !locked_ff;

    // Only bit 0 stored; upper bits of the word are dropped
    assign nxt_integration_mode_control = (wr_ok && hit_integration_mode_control) ? req.wdata[0] : integration_mode_control_ff;

    // Claim bits beyond CLAIM_W are not implemented and ignore writes
    // One cell per claim bit; set and clear sit at different words, so never collide
    for (genvar gi = 0; gi < CLAIM_W; gi++) begin : g_claim
        wire logic set_bit = wr_ok && hit_cset && req.wdata[gi];
        wire logic clr_bit = wr_ok && hit_cclr && req.wdata[gi];
        assign nxt_claim[gi] = set_bit ? 1'b1 : (clr_bit ? 1'b0 : claim_ff[gi]);
    end

    // Any other value than the key relocks: a permitted mapping
    assign nxt_locked = (wr_go && hit_lar) ? (req.wdata != UNLOCK_KEY) : locked_ff;

    assign nxt_rdata = rd_go ? read_mux(widx) : rdata_ff;
    assign nxt_ready = clk_en ? setup_phase : ready_ff;

    // ==========================================================
    // Read data mux
    function automatic logic [DATA_W-1:0] read_mux(input widx_t w);
        logic [DATA_W-1:0] d;
        d = RESET_ZERO;
        if (w == word_idx(OFF_INTEGRATION_MODE_CONTROL)) begin
            d[0] = integration_mode_control_ff;
        end else if (w == word_idx(OFF_CLAIM_TAG_SET)) begin
            d[CLAIM_W-1:0] = {CLAIM_W{1'b1}};
        end else if (w == word_idx(OFF_CLAIM_TAG_CLEAR)) begin
            d[CLAIM_W-1:0] = claim_ff;
        end else if (w == word_idx(OFF_LOCK_STATUS)) begin
            // Bit 0 lock implemented, bit 1 locked, bit 2 32-bit access
            d[2:0] = {1'b0, locked_ff, 1'b1};
        end else if (w == word_idx(OFF_DEVICE_TYPE_ID)) begin
            d[7:0] = DEVICE_TYPE;
        end else if (w == word_idx(OFF_PERIPH_IDENT_4)) begin
            d[7:0] = {SIZE_4KB_COUNT, DESIGNER_CONT};
        end else if (w == word_idx(OFF_PERIPH_IDENT_0)) begin
            d[7:0] = PART_NUMBER[7:0];
        end else if (w == word_idx(OFF_PERIPH_IDENT_0) + widx_t'(1)) begin
            d[7:0] = {DESIGNER_ID[3:0], PART_NUMBER[11:8]};
        end else if (w == word_idx(OFF_PERIPH_IDENT_0) + widx_t'(2)) begin
            d[7:0] = {REVISION, 1'b1, DESIGNER_ID[6:4]};
        end else if (w == word_idx(OFF_COMPONENT_IDENT_0)) begin
            d[7:0] = PREAMBLE_BYTE_0;
        end else if (w == word_idx(OFF_COMPONENT_IDENT_1)) begin
            // Debug class, not the legacy code
            d[7:0] = {CLASS_DEBUG, PREAMBLE_NIBBLE_1};
        end else if (w == word_idx(OFF_COMPONENT_IDENT_2)) begin
            d[7:0] = PREAMBLE_BYTE_2;
        end else if (w == word_idx(OFF_COMPONENT_IDENT_3)) begin
            d[7:0] = PREAMBLE_BYTE_3;
        end
        // Lock access is write-only and reads zero
        read_mux = d;
    endfunction

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            integration_mode_control_ff <= 1'b0;
            claim_ff <= '0;
            locked_ff <= 1'b1;
            rdata_ff <= RESET_ZERO;
            ready_ff <= 1'b0;
            slverr_ff <= 1'b0;
        end else if (clk_en) begin
            integration_mode_control_ff <= nxt_integration_mode_control;
            claim_ff <= nxt_claim;
            locked_ff <= nxt_locked;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            slverr_ff <= 1'b0;
        end
    end

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = slverr_ff;
    assign integration_mode = integration_mode_control_ff;
    assign claim_tags = claim_ff;
    assign locked = locked_ff;

    // ==========================================================
    // Checks
    sequence rd_cid3_s;
        clk_en && rd_go && widx == word_idx(OFF_COMPONENT_IDENT_3);
    endsequence

    cid3_value_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_cid3_s |=> prdata == {24'h0, PREAMBLE_BYTE_3})
        else $error("ident word 3 wrong");
    cid1_class_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && widx == word_idx(OFF_COMPONENT_IDENT_1)) |=> prdata[7:4] == CLASS_DEBUG)
        else $error("class field wrong");
    lar_read_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && hit_lar) |=> prdata == RESET_ZERO)
        else $error("write-only word read nonzero");
    integration_mode_control_upper_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && hit_integration_mode_control) |=> prdata[31:1] == '0)
        else $error("unstored bits not zero");
    mgmt_hole_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && widx == word_idx(OFF_DEVICE_AFFINITY_0)) |=> prdata == RESET_ZERO)
        else $error("unimplemented word nonzero");
    ready_timing_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && setup_phase) |=> pready ##1 (!pready || !$past(clk_en) || $past(setup_phase)))
        else $error("pready timing wrong");
    claim_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_ok && hit_cset) |=> (claim_tags & $past(req.wdata[CLAIM_W-1:0])) ==
            $past(req.wdata[CLAIM_W-1:0]))
        else $error("claim set lost");
    locked_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_go && locked_ff && hit_integration_mode_control) |=> $stable(integration_mode))
        else $error("write while locked took effect");

    // Read or unlocked write taken at one word of the window
    sequence rd_at_s(widx_t w);
        rd_go && widx == w;
    endsequence
    sequence wr_at_s(widx_t w);
        wr_ok && widx == w;
    endsequence
    // One-cycle answer, then the strobe drops again
    sequence answer_s;
        pready ##1 !pready;
    endsequence

    cid0_value_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_COMPONENT_IDENT_0)) |=> prdata == {24'h0, PREAMBLE_BYTE_0})
        else $error("ident word 0 wrong");
    cid2_value_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_COMPONENT_IDENT_2)) |=> prdata == {24'h0, PREAMBLE_BYTE_2})
        else $error("ident word 2 wrong");
    cid1_preamble_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_COMPONENT_IDENT_1)) |=>
            (prdata[3:0] == PREAMBLE_NIBBLE_1 && prdata[31:8] == '0))
        else $error("ident word 1 preamble wrong");
    class_legacy_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_COMPONENT_IDENT_1)) |=> prdata[7:4] != CLASS_LEGACY)
        else $error("legacy class reported");
    periph_ident_2_jedec_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_PERIPH_IDENT_0) + widx_t'(2)) |=>
            (prdata[3] && prdata[31:8] == '0))
        else $error("peripheral word 2 wrong");
    size_count_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_PERIPH_IDENT_4)) |=> prdata[7:4] == SIZE_4KB_COUNT)
        else $error("block count wrong");
    lock_status_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_LOCK_STATUS)) |=> prdata == {30'h0, $past(locked), 1'b1})
        else $error("lock status wrong");
    unlock_key_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_go && hit_lar && req.wdata == UNLOCK_KEY) |=> !locked)
        else $error("key did not unlock");
    relock_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_go && hit_lar && req.wdata != UNLOCK_KEY) |=> locked)
        else $error("other value did not lock");
    ctrl_region_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && widx < word_idx(OFF_MGMT_FIRST)) |=> prdata == RESET_ZERO)
        else $error("control region word nonzero");
    ro_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr_go && hit_lsr) |=>
            ($stable(locked) && $stable(claim_tags) && $stable(integration_mode)))
        else $error("read-only write took effect");
    claim_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_at_s(word_idx(OFF_CLAIM_TAG_CLEAR)) |=>
            (claim_tags & $past(req.wdata[CLAIM_W-1:0])) == '0)
        else $error("claim clear lost");
    claim_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_CLAIM_TAG_SET)) |=> prdata == DATA_W'({CLAIM_W{1'b1}}))
        else $error("claim mask wrong");
    integration_mode_control_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_at_s(word_idx(OFF_INTEGRATION_MODE_CONTROL)) |=>
            integration_mode == $past(req.wdata[0]))
        else $error("mode bit write lost");
    arch_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_at_s(word_idx(OFF_DEVICE_ARCHITECTURE)) |=> prdata == RESET_ZERO)
        else $error("architecture word nonzero");
    config_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (rd_go && (widx == word_idx(OFF_DEVICE_CONFIG_0) ||
            widx == word_idx(OFF_DEVICE_CONFIG_1) ||
            widx == word_idx(OFF_DEVICE_CONFIG_2))) |=> prdata == RESET_ZERO)
        else $error("configuration word nonzero");
    enable_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
        !clk_en |=> ($stable(prdata) && $stable(pready) && $stable(locked) &&
            $stable(claim_tags) && $stable(integration_mode)))
        else $error("state moved while disabled");
    rdata_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !rd_go |=> $stable(prdata))
        else $error("read data changed without read");
    ready_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && setup_phase ##1 clk_en) |-> answer_s)
        else $error("answer not one cycle");
    no_error_a: assert property (@(posedge clk) disable iff (!nrst)
        pready |-> !pslverr)
        else $error("error response given");
endmodule

`default_nettype wire

// ==== verif/dbg_apb_master.sv ====
// Requester model for the identification register window, one APB master.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Requester
module dbg_apb_master
    import dbg_id_pkg::*;
(
    // Clock
    input wire logic clk,
    // APB requester side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready
);
    // Edges waited for the answer in the last transfer
    int lat = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // Whole words only; the bench always hands word-aligned addresses
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        #1;
        psel = 1'b1;
        penable = 1'b0;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(posedge clk);
        #1 penable = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        lat = n;
        r = (pready === 1'b1) ? prdata : 'x;
    endtask
    // Released data shows a changed pattern, never the last word
    task automatic idle();
        #1;
        psel = 1'b0;
        penable = 1'b0;
        pwdata = ~pwdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/debug_component_id_regs_test.sv ====
// Self-checking bench for the identification register window.
// Assumes the requester model drives the APB port; one clock domain.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench
module debug_component_id_regs_test;
    import dbg_id_pkg::*;
    logic clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
    logic integration_mode, locked;
    logic [CLAIM_W-1:0] claim_tags;
    logic [ADDR_W-1:0] paddr, a;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [11:0] gaps [7] = '{12'hf04, 12'hfa8, 12'hfb8, 12'hfc0, 12'hfc4, 12'hfc8, 12'hfd4};
    int bad_count = 0;
    int n_checks = 0;
    int seed = 88049;
    int m_im = 0;
    int m_claim = 0;
    int m_lock = 1;
    int i;
    debug_component_id_regs debug_component_id_regs_inst (.clk, .nrst, .clk_en, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .integration_mode, .claim_tags, .locked);
    dbg_apb_master dbg_apb_master_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready);
    // ==========================================================
    // Reference model
    function automatic logic [31:0] model_rd(logic [11:0] ad);
        case ({ad[11:2], 2'b00})
            12'hf00: return m_im;
            12'hf08: return (1 << CLAIM_W) - 1;
            12'hf44: return m_claim;
            12'hfb4: return 1 + 2 * m_lock;
            12'hfcc: return DEVICE_TYPE;
            12'hfd0: return {SIZE_4KB_COUNT, DESIGNER_CONT};
            12'hfe0: return PART_NUMBER[7:0];
            12'hfe4: return {DESIGNER_ID[3:0], PART_NUMBER[11:8]};
            12'hfe8: return {REVISION, 1'b1, DESIGNER_ID[6:4]};
            12'hff4: return {CLASS_DEBUG, PREAMBLE_NIBBLE_1};
            12'hff8: return PREAMBLE_BYTE_2;
            12'hffc: return PREAMBLE_BYTE_3;
            default: return 0;
        endcase
    endfunction
    function automatic void model_wr(logic [11:0] ad, logic [31:0] d);
        logic [11:0] w;
        w = {ad[11:2], 2'b00};
        if (w == OFF_LOCK_ACCESS) m_lock = (d != UNLOCK_KEY);
        else if (m_lock == 0 && w == 12'hf00) m_im = d[0];
        else if (m_lock == 0 && w == 12'hf08) m_claim = m_claim | d[3:0];
        else if (m_lock == 0 && w == 12'hf44) m_claim = m_claim & ~d[3:0] & 15;
    endfunction
    // ==========================================================
    // Compares and transfers
    task automatic chk_rd(logic [11:0] ad, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error read %h expected %h seen %h", ad, e, g);
        end
    endtask
    task automatic chk_pins();
        logic [6:0] e;
        e = {m_im[0], m_claim[3:0], m_lock[0], 1'b0};
        n_checks++;
        if ({integration_mode, claim_tags, locked, pslverr} !== e) begin
            bad_count++;
            $display("Error pins expected %b seen %b", e,
                     {integration_mode, claim_tags, locked, pslverr});
        end
    endtask
    // The answer is due at the edge after the setup edge
    task automatic chk_wait(logic [11:0] ad, int g);
        n_checks++;
        if (g != 1) begin
            bad_count++;
            $display("Error wait %h expected 1 seen %0d", ad, g);
        end
    endtask
    task automatic rd(logic [11:0] ad);
        dbg_apb_master_inst.xfer(1'b0, ad, 32'h0, r);
        chk_wait(ad, dbg_apb_master_inst.lat);
        chk_rd(ad, model_rd(ad), r);
    endtask
    task automatic wr(logic [11:0] ad, logic [31:0] d);
        dbg_apb_master_inst.xfer(1'b1, ad, d, r);
        chk_wait(ad, dbg_apb_master_inst.lat);
        model_wr(ad, d);
    endtask
    task automatic settle();
        dbg_apb_master_inst.idle();
        @(posedge clk);
        chk_pins();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        @(posedge clk);
        chk_pins();
        for (i = 0; i < 4; i++) rd(12'(12'hff0 + 4 * i));
        for (i = 0; i < 8; i++) rd(12'(12'hfd0 + 4 * i));
        rd(OFF_DEVICE_TYPE_ID);
        rd(OFF_LOCK_STATUS);
        wr(12'hf00, 32'hffff_ffff);
        wr(12'hf08, 32'hf);
        rd(12'hf00);
        rd(OFF_CLAIM_TAG_CLEAR);
        wr(OFF_LOCK_ACCESS, $random(seed));
        wr(OFF_LOCK_ACCESS, UNLOCK_KEY);
        settle();
        #1 clk_en = 1'b0;
        repeat (4) @(posedge clk);
        chk_pins();
        #1 clk_en = 1'b1;
        @(posedge clk);
        rd(OFF_LOCK_ACCESS);
        rd(OFF_LOCK_STATUS);
        repeat (4) begin
            wr(12'hf00, $random(seed));
            rd(12'hf00);
            wr(12'hf08, $random(seed));
            rd(OFF_CLAIM_TAG_SET);
            wr(12'hf44, $random(seed));
            rd(OFF_CLAIM_TAG_CLEAR);
            settle();
        end
        wr(OFF_COMPONENT_IDENT_0, 32'hffff_ffff);
        rd(OFF_COMPONENT_IDENT_0);
        wr(OFF_LOCK_STATUS, $random(seed));
        rd(OFF_LOCK_STATUS);
        foreach (gaps[j]) begin
            wr(gaps[j], $random(seed));
            rd(gaps[j]);
        end
        // Second reset in mid-run: all state back to its reset values
        #1 nrst = 1'b0;
        m_im = 0;
        m_claim = 0;
        m_lock = 1;
        @(posedge clk);
        chk_pins();
        #1 nrst = 1'b1;
        @(posedge clk);
        chk_pins();
        repeat (8) begin
            a = 12'($unsigned($random(seed)) % 32'hf00) & 12'hffc;
            wr(a, $random(seed));
            rd(a);
        end
        wr(OFF_LOCK_ACCESS, 32'h0);
        wr(12'hf00, 32'h0);
        rd(OFF_LOCK_STATUS);
        settle();
        complete_run();
    end
endmodule
`default_nettype wire
